// ---- spcl_pkg.sv ----
// Shared constants, field layout and state codes for the SPI control block
package spcl_pkg;
    // Register byte addresses on the Wishbone bus
    localparam logic [7:0] SPCL_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] SPCL_ADDR_TRANSMIT_DATA_REGISTER = 8'h04;
    localparam logic [7:0] SPCL_ADDR_RECEIVE_DATA = 8'h08;
    localparam logic [7:0] SPCL_ADDR_STATUS = 8'h0c;

    // Reset values
    localparam logic [15:0] SPCL_CONTROL_RESET = 16'h0000;
    localparam logic [7:0] SPCL_BYTE_RESET = 8'h00;

    // Byte shifted out when zero fill is selected and nothing is queued
    localparam logic [7:0] SPCL_FILL_BYTE = 8'h00;

    // Status register bit positions
    localparam int SPCL_STAT_TX_VALID = 0;
    localparam int SPCL_STAT_RX_FULL = 1;
    localparam int SPCL_STAT_BUSY = 2;
    localparam int SPCL_STAT_EVENT = 3;

    // Bit counter values within one byte
    localparam logic [3:0] SPCL_CNT_LAST = 4'h7;
    localparam logic [3:0] SPCL_CNT_DONE = 4'h8;
    localparam logic [3:0] SPCL_CNT_ZERO = 4'h0;
    localparam logic [3:0] SPCL_CNT_ONE = 4'h1;

    // Link clocks per half bit when generating the serial clock
    localparam logic [3:0] SPCL_HALF_CYC = 4'h2;

    // Control register low byte, bit 7 down to bit 0
    typedef struct packed {
        logic zero_fill_enable;
        logic transfer_trigger_mode;
        logic lsb_first_enable;
        logic open_drain_out_enable;
        logic clock_idle_polarity;
        logic clock_phase_select;
        logic master_select;
        logic port_enable;
    } spcl_ctrl_t;

    // Serial engine states
    typedef enum logic [2:0] {
        SPCL_IDLE = 3'b001,
        SPCL_MRUN = 3'b010,
        SPCL_SRUN = 3'b100
    } spcl_state_t;
endpackage

// ---- spcl_sync.sv ----
// Two flip-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ns
module spcl_sync #(
    parameter int WIDTH = 1
)
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic stage1;
            // First stage feeds only the second stage
            always_ff @(posedge clk_in or negedge reset_n_in)
            begin
                if (!reset_n_in)
                begin
                    stage1 <= 1'b0;
                    q_out[i] <= 1'b0;
                end
                else
                begin
                    stage1 <= d_in[i];
                    q_out[i] <= stage1;
                end
            end
        end
    endgenerate
endmodule

// ---- spcl_event.sv ----
// Toggle crossing that turns a far-domain toggle into a local pulse
`timescale 1ns/1ns
module spcl_event (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic toggle_in,
    output logic pulse_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Edge detection reads only settled stages
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= toggle_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign pulse_out = stage2 ^ stage3;
endmodule

// ---- spcl_spi_control.sv ----
// SPI port: control register, Wishbone slave and serial engine
// What this block does
// - Zero fill set and nothing queued: shift out byte 0x00.
// - Zero fill clear and nothing queued: resend the last transmitted byte.
// - Trigger mode set: transmit write starts master transfer; event on transmit empty and engine idle.
// - Trigger mode clear: receive read starts master transfer; event on receive full.
// - Bit 5 set shifts LSB first, clear shifts MSB first.
// - Bit 4 set drives data outputs open-drain, clear drives push-pull.
// - Bit 3 set idles serial clock high, clear idles it low.
// - Bit 2 set pulses clock at bit start, clear at bit end.
// - Bit 1 set makes port master generating clock, clear makes it slave.
// - Bit 0 set activates the port; clear disables all transfers.
`timescale 1ns/1ns
module spcl_spi_control
    import spcl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic link_clk_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe_n_out,
    input wire logic ss_n_in,
    output logic ss_n_out,
    output logic ss_n_oe_n_out,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n_out,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    output logic spi_event_out
);
    // System domain state
    logic [15:0] control;
    spcl_ctrl_t ctrl;
    logic wb_ack;
    logic [31:0] wb_rdata;
    logic wb_take;
    logic hit_ctrl;
    logic hit_tx;
    logic hit_rx;
    logic hit_stat;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    logic wr_ctrl;
    logic wr_tx;
    logic rd_rx;
    logic [7:0] tx_hold;
    logic tx_req;
    logic tx_valid;
    logic [7:0] rx_data;
    logic rx_full;
    logic rx_pulse;
    logic start_tgl;
    logic event_r;
    logic [1:0] back_sync;
    logic tx_ack_s;
    logic busy_s;

    // Link domain state
    logic link_rst_n;
    logic [12:0] fwd_sync;
    spcl_ctrl_t cfg;
    logic tx_req_l;
    logic sclk_s;
    logic ss_n_s;
    logic mosi_s;
    logic miso_s;
    logic sclk_d;
    logic start_pulse;
    logic start_pend;
    logic tx_ack_l;
    logic pending;
    spcl_state_t state;
    spcl_state_t next_state;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic [7:0] next_rx;
    logic [7:0] next_byte;
    logic [7:0] last_sent;
    logic [7:0] rx_word;
    logic rx_tgl;
    logic [3:0] bit_cnt;
    logic [3:0] div_cnt;
    logic half;
    logic m_tick;
    logic lead;
    logic trail;
    logic sample_ev;
    logic shift_ev;
    logic end_ev;
    logic done_ev;
    logic load_ev;
    logic start_m;
    logic start_s;
    logic din;
    logic dout;
    logic clk_active;

    assign ctrl = spcl_ctrl_t'(control[7:0]);
    assign wb_take = wb_cyc_in & wb_stb_in & ~wb_ack;
    assign wb_ack_out = wb_ack;
    assign wb_dat_out = wb_rdata;
    assign tx_valid = tx_req ^ tx_ack_s;
    assign tx_ack_s = back_sync[0];
    assign busy_s = back_sync[1];

    // Address decoding; unmapped addresses hit nothing
    always_comb
    begin
        hit_ctrl = 1'b0;
        hit_tx = 1'b0;
        hit_rx = 1'b0;
        hit_stat = 1'b0;
        if (wb_adr_in == SPCL_ADDR_CONTROL)
            hit_ctrl = 1'b1;
        else if (wb_adr_in == SPCL_ADDR_TRANSMIT_DATA_REGISTER)
            hit_tx = 1'b1;
        else if (wb_adr_in == SPCL_ADDR_RECEIVE_DATA)
            hit_rx = 1'b1;
        else if (wb_adr_in == SPCL_ADDR_STATUS)
            hit_stat = 1'b1;
    end

    // Status word assembly
    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[SPCL_STAT_TX_VALID] = tx_valid;
        stat_word[SPCL_STAT_RX_FULL] = rx_full;
        stat_word[SPCL_STAT_BUSY] = busy_s;
        stat_word[SPCL_STAT_EVENT] = event_r;
    end

    // Read data selection, zero for unmapped
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux = {16'h0000, control};
        else if (hit_tx)
            rd_mux = {24'h00_0000, tx_hold};
        else if (hit_rx)
            rd_mux = {24'h00_0000, rx_data};
        else if (hit_stat)
            rd_mux = stat_word;
    end

    assign wr_ctrl = wb_take & wb_we_in & hit_ctrl;
    assign wr_tx = wb_take & wb_we_in & hit_tx & wb_sel_in[0];
    assign rd_rx = wb_take & ~wb_we_in & hit_rx;

    // Single wait state acknowledge
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            wb_ack <= 1'b0;
        else
            wb_ack <= wb_cyc_in & wb_stb_in & ~wb_ack;
    end

    // Read data register, presented together with ack
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            wb_rdata <= 32'h0000_0000;
        else if (wb_take & ~wb_we_in)
            wb_rdata <= rd_mux;
    end

    // Control register; upper byte is stored for software only
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            control <= SPCL_CONTROL_RESET;
        else if (wr_ctrl)
        begin
            if (wb_sel_in[0])
                control[7:0] <= wb_dat_in[7:0];
            if (wb_sel_in[1])
                control[15:8] <= wb_dat_in[15:8];
        end
    end

    // One-word transmit queue; a write while full is dropped
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_hold <= SPCL_BYTE_RESET;
            tx_req <= 1'b0;
        end
        else if (wr_tx & ctrl.port_enable & ~tx_valid)
        begin
            tx_hold <= wb_dat_in[7:0];
            tx_req <= ~tx_req;
        end
    end

    // Receive read launches a transfer in read-trigger master mode
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            start_tgl <= 1'b0;
        else if (rd_rx & ctrl.port_enable & ctrl.master_select
                 & ~ctrl.transfer_trigger_mode)
            start_tgl <= ~start_tgl;
    end

    // Receive holding byte; new byte is discarded while unread
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_data <= SPCL_BYTE_RESET;
            rx_full <= 1'b0;
        end
        else if (rx_pulse & (~rx_full | rd_rx))
        begin
            rx_data <= rx_word;
            rx_full <= 1'b1;
        end
        else if (rd_rx)
            rx_full <= 1'b0;
    end

    // Event level follows the selected trigger mode
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            event_r <= 1'b0;
        else if (ctrl.transfer_trigger_mode)
            event_r <= ctrl.port_enable & ~tx_valid & ~busy_s;
        else
            event_r <= ctrl.port_enable & rx_full;
    end

    assign spi_event_out = event_r;

    // Link to system crossings
    spcl_sync #(.WIDTH(2)) u_back_sync (
        .clk_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .d_in({state != SPCL_IDLE, tx_ack_l}),
        .q_out(back_sync)
    );

    spcl_event u_rx_event (
        .clk_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .toggle_in(rx_tgl),
        .pulse_out(rx_pulse)
    );

    // Link reset is released in step with the link clock
    spcl_sync #(.WIDTH(1)) u_link_rst (
        .clk_in(link_clk_in),
        .reset_n_in(reset_n_in),
        .d_in(1'b1),
        .q_out(link_rst_n)
    );

    // Config is quasi-static; change it only while the port is idle
    spcl_sync #(.WIDTH(13)) u_fwd_sync (
        .clk_in(link_clk_in),
        .reset_n_in(link_rst_n),
        .d_in({control[7:0], tx_req, sclk_in, ss_n_in, mosi_in, miso_in}),
        .q_out(fwd_sync)
    );

    spcl_event u_start_event (
        .clk_in(link_clk_in),
        .reset_n_in(link_rst_n),
        .toggle_in(start_tgl),
        .pulse_out(start_pulse)
    );

    assign cfg = spcl_ctrl_t'(fwd_sync[12:5]);
    assign tx_req_l = fwd_sync[4];
    assign sclk_s = fwd_sync[3];
    assign ss_n_s = fwd_sync[2];
    assign mosi_s = fwd_sync[1];
    assign miso_s = fwd_sync[0];
    assign pending = tx_req_l ^ tx_ack_l;

    // Next byte to shift: queued word, else filler
    always_comb
    begin
        if (pending)
            next_byte = tx_hold;
        else if (cfg.zero_fill_enable)
            next_byte = SPCL_FILL_BYTE;
        else
            next_byte = last_sent;
    end

    // Serial clock edges seen by the slave
    always_comb
    begin
        lead = (sclk_s != sclk_d) & (sclk_s != cfg.clock_idle_polarity);
        trail = (sclk_s != sclk_d) & (sclk_s == cfg.clock_idle_polarity);
    end

    // Transfer events for both roles
    always_comb
    begin
        m_tick = (div_cnt == SPCL_HALF_CYC - SPCL_CNT_ONE);
        start_m = 1'b0;
        start_s = 1'b0;
        sample_ev = 1'b0;
        shift_ev = 1'b0;
        end_ev = 1'b0;
        next_state = state;
        if (state == SPCL_IDLE)
        begin
            // Master starts on queued word or on receive read
            start_m = cfg.port_enable & cfg.master_select
                & (cfg.transfer_trigger_mode ? pending : start_pend);
            start_s = cfg.port_enable & ~cfg.master_select & ~ss_n_s;
        end
        else if (state == SPCL_MRUN)
        begin
            // Sample at bit end: pin sync lag makes mid bit too early
            end_ev = m_tick & half;
            sample_ev = end_ev;
            shift_ev = end_ev & (bit_cnt != SPCL_CNT_LAST);
        end
        else if (state == SPCL_SRUN)
        begin
            // Sample edge depends on phase
            sample_ev = cfg.clock_phase_select ? trail : lead;
            shift_ev = (cfg.clock_phase_select ? lead : trail)
                & (bit_cnt != SPCL_CNT_ZERO) & (bit_cnt != SPCL_CNT_DONE);
        end
        done_ev = sample_ev & (bit_cnt == SPCL_CNT_LAST);
        load_ev = start_m | start_s | (done_ev & (state == SPCL_SRUN));
        case (state)
            SPCL_IDLE:
            begin
                if (start_m)
                    next_state = SPCL_MRUN;
                else if (start_s)
                    next_state = SPCL_SRUN;
            end
            SPCL_MRUN:
            begin
                if (~cfg.port_enable | (end_ev & ~shift_ev))
                    next_state = SPCL_IDLE;
            end
            SPCL_SRUN:
            begin
                if (~cfg.port_enable | ss_n_s)
                    next_state = SPCL_IDLE;
            end
            default:
                next_state = SPCL_IDLE;
        endcase
    end

    // Engine state register
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
            state <= SPCL_IDLE;
        else
            state <= next_state;
    end

    // Pending receive-read start until master picks it up
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
            start_pend <= 1'b0;
        else if (start_pulse)
            start_pend <= 1'b1;
        else if (start_m | ~cfg.port_enable)
            start_pend <= 1'b0;
    end

    // Half-bit divider for the generated clock
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            div_cnt <= SPCL_CNT_ZERO;
            half <= 1'b0;
        end
        else if (state != SPCL_MRUN)
        begin
            div_cnt <= SPCL_CNT_ZERO;
            half <= 1'b0;
        end
        else if (m_tick)
        begin
            div_cnt <= SPCL_CNT_ZERO;
            half <= ~half;
        end
        else
            div_cnt <= div_cnt + SPCL_CNT_ONE;
    end

    // Bit counter counts samples taken
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
            bit_cnt <= SPCL_CNT_ZERO;
        else if (load_ev)
            bit_cnt <= SPCL_CNT_ZERO;
        else if (sample_ev)
            bit_cnt <= bit_cnt + SPCL_CNT_ONE;
    end

    // Transmit shift register and queue acknowledge
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            tx_sh <= SPCL_BYTE_RESET;
            last_sent <= SPCL_BYTE_RESET;
            tx_ack_l <= 1'b0;
        end
        else if (load_ev)
        begin
            tx_sh <= next_byte;
            last_sent <= next_byte;
            if (pending)
                tx_ack_l <= ~tx_ack_l;
        end
        else if (shift_ev)
        begin
            if (cfg.lsb_first_enable)
                tx_sh <= {1'b0, tx_sh[7:1]};
            else
                tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    assign din = cfg.master_select ? miso_s : mosi_s;

    // Incoming bit lands at the end matching the bit order
    always_comb
    begin
        if (cfg.lsb_first_enable)
            next_rx = {din, rx_sh[7:1]};
        else
            next_rx = {rx_sh[6:0], din};
    end

    // Receive shift register
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
            rx_sh <= SPCL_BYTE_RESET;
        else if (sample_ev)
            rx_sh <= next_rx;
    end

    // Completed byte stays stable a full byte time for the crossing
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            rx_word <= SPCL_BYTE_RESET;
            rx_tgl <= 1'b0;
        end
        else if (done_ev)
        begin
            rx_word <= next_rx;
            rx_tgl <= ~rx_tgl;
        end
    end

    // Slave clock history for edge detection
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
            sclk_d <= 1'b0;
        else
            sclk_d <= sclk_s;
    end

    assign dout = cfg.lsb_first_enable ? tx_sh[0] : tx_sh[7];
    assign clk_active = (state == SPCL_MRUN)
        & (cfg.clock_phase_select ? ~half : half);

    // Registered pins; data and clock share one cycle of delay
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            sclk_out <= 1'b0;
            sclk_oe_n_out <= 1'b1;
            ss_n_out <= 1'b1;
            ss_n_oe_n_out <= 1'b1;
            mosi_out <= 1'b0;
            mosi_oe_n_out <= 1'b1;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end
        else
        begin
            // Open-drain only pulls low; high is left to pull-ups
            mosi_out <= cfg.open_drain_out_enable ? 1'b0 : dout;
            miso_out <= cfg.open_drain_out_enable ? 1'b0 : dout;
            sclk_out <= cfg.clock_idle_polarity ^ clk_active;
            ss_n_out <= state != SPCL_MRUN;
            sclk_oe_n_out <= ~(cfg.port_enable & cfg.master_select);
            ss_n_oe_n_out <= ~(cfg.port_enable & cfg.master_select);
            mosi_oe_n_out <= ~(cfg.port_enable & cfg.master_select)
                | (cfg.open_drain_out_enable & dout);
            miso_oe_n_out <= ~(cfg.port_enable & ~cfg.master_select & ~ss_n_s)
                | (cfg.open_drain_out_enable & dout);
        end
    end
endmodule

// ---- spcl_spi_control_asserts.sv ----
// Checker: bus timing and serial framing of the SPI control block
`timescale 1ns/1ns
module spcl_spi_control_asserts
    import spcl_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic link_clk_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic sclk_out,
    input wire logic ss_n_out,
    input wire logic mosi_out,
    input wire logic mosi_oe_n_out
);
    spcl_ctrl_t ctrl;
    logic sclk_q;
    logic [4:0] tgl;
    wire take = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire ctl_sel = wb_adr_in == SPCL_ADDR_CONTROL;
    // Shadow of the control byte; safe across domains, idle changes only
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
        if (!reset_n_in)
            ctrl <= SPCL_CONTROL_RESET[7:0];
        else if (take && wb_we_in && wb_sel_in[0] && ctl_sel)
            ctrl <= wb_dat_in[7:0];
    // Clock toggles in a frame, the first one included
    always_ff @(posedge link_clk_in or negedge reset_n_in)
        if (!reset_n_in)
        begin
            sclk_q <= 1'b0;
            tgl <= 5'h0;
        end
        else
        begin
            sclk_q <= sclk_out;
            tgl <= ($fell(ss_n_out) ? 5'h0 : tgl) + 5'(sclk_out != sclk_q);
        end
    property p_ack_wait;
        @(posedge clk_sys_in) disable iff (!reset_n_in) take |=> wb_ack_out;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("ack late");
    property p_ctrl_read;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        take && !wb_we_in && ctl_sel |=> wb_dat_out[7:0] == ctrl;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
    property p_idle;
        @(posedge link_clk_in) disable iff (!reset_n_in)
        $fell(ss_n_out) |-> $past(sclk_out) == ctrl.clock_idle_polarity;
    endproperty
    a_idle: assert property (p_idle) else $error("idle level");
    property p_phase;
        @(posedge link_clk_in) disable iff (!reset_n_in) $fell(ss_n_out)
        |-> ##1 (sclk_out != ctrl.clock_idle_polarity) == ctrl.clock_phase_select;
    endproperty
    a_phase: assert property (p_phase) else $error("phase");
    property p_od;
        @(posedge link_clk_in) disable iff (!reset_n_in)
        ctrl.open_drain_out_enable && !ss_n_out && !mosi_oe_n_out |-> !mosi_out;
    endproperty
    a_od: assert property (p_od) else $error("drives high");
    property p_pp;
        @(posedge link_clk_in) disable iff (!reset_n_in)
        !ctrl.open_drain_out_enable && !ss_n_out |-> !mosi_oe_n_out;
    endproperty
    a_pp: assert property (p_pp) else $error("not driven");
    property p_master;
        @(posedge link_clk_in) disable iff (!reset_n_in)
        $fell(ss_n_out) |-> ctrl.master_select && ctrl.port_enable;
    endproperty
    a_master: assert property (p_master) else $error("frame");
    property p_tgl;
        @(posedge link_clk_in) disable iff (!reset_n_in)
        $rose(ss_n_out) |-> ##1 tgl == 5'h10;
    endproperty
    a_tgl: assert property (p_tgl) else $error("clock count");
    c_lsb: cover property (@(posedge link_clk_in)
        $fell(ss_n_out) && ctrl.lsb_first_enable);
    c_od: cover property (@(posedge link_clk_in)
        !ss_n_out && mosi_oe_n_out && ctrl.open_drain_out_enable);
    c_read: cover property (@(posedge clk_sys_in) take && !wb_we_in);
endmodule
bind spcl_spi_control spcl_spi_control_asserts u_chk (
    .clk_sys_in, .reset_n_in, .link_clk_in, .wb_cyc_in, .wb_stb_in,
    .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
    .wb_ack_out, .sclk_out, .ss_n_out, .mosi_out, .mosi_oe_n_out
);

// ---- spcl_spi_slave_model.sv ----
// Slave model: samples on the programmed edge, answers MSB first
`timescale 1ns/1ns
module spcl_spi_slave_model
    import spcl_pkg::*;
(
    input wire logic sclk_in,
    input wire logic ss_n_in,
    input wire logic mosi_in,
    input wire logic mode_in,
    input wire logic [7:0] tx_in,
    output logic miso_out,
    output logic [7:0] rx_out
);
    logic [7:0] sh;
    // Released line shows the pull-up level
    assign miso_out = ss_n_in ? 1'b1 : sh[7];
    // Reply loaded at select
    always @(negedge ss_n_in)
        sh = tx_in;
    // Mode is polarity xor phase; next bit follows each sample
    always @(sclk_in)
        if (!ss_n_in && sclk_in == !mode_in)
        begin
            rx_out = {rx_out[6:0], mosi_in};
            sh = {sh[6:0], 1'b0};
        end
endmodule

// ---- spcl_spi_control_tb.sv ----
// Bench for the SPI control block with a slave on the serial side
`timescale 1ns/1ns
module spcl_spi_control_tb
    import spcl_pkg::*;
();
    logic clk_sys_in = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n_in = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic mode = 1'b0;
    logic [7:0] reply = 8'h00;
    logic [31:0] rdata;
    logic [7:0] got, b;
    logic [3:0] sel = 4'hf;
    int fail_count = 0, num_checks = 0, frames = 0;
    wire sclk_o, sclk_oe, ss_o, ss_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    wire ack, evt, miso_m;
    wire [31:0] dat_o;
    // Every line has a pull-up
    wire sclk_w = sclk_oe | sclk_o;
    wire ss_w = ss_oe | ss_o;
    wire mosi_w = mosi_oe | mosi_o;
    wire miso_w = (miso_oe | miso_o) & miso_m;
    // Clocks, phases unrelated
    initial forever #50 clk_sys_in = ~clk_sys_in;
    initial #7 forever #15 link_clk = ~link_clk;
    // Frames seen on the wire
    always @(negedge ss_w) frames++;
    spcl_spi_control DUT (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .link_clk_in(link_clk), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(dat_o), .wb_ack_out(ack),
        .sclk_in(sclk_w), .sclk_out(sclk_o), .sclk_oe_n_out(sclk_oe),
        .ss_n_in(ss_w), .ss_n_out(ss_o), .ss_n_oe_n_out(ss_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_n_out(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_o), .miso_oe_n_out(miso_oe),
        .spi_event_out(evt)
    );
    spcl_spi_slave_model u_slave (
        .sclk_in(sclk_w), .ss_n_in(ss_w), .mosi_in(mosi_w),
        .mode_in(mode), .tx_in(reply), .miso_out(miso_m), .rx_out(got)
    );
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // One classic cycle; idles a cycle after release
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_sys_in);
            n++;
        end
        while (ack !== 1'b1);
        rdata = dat_o;
        cyc <= 1'b0;
        @(posedge clk_sys_in);
        chk(n < 50, 1'b1);
    endtask
    // Poll status until a byte waits
    task automatic wait_rx;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, SPCL_ADDR_STATUS, 32'h0);
            n++;
        end
        while (rdata[SPCL_STAT_RX_FULL] !== 1'b1 && n < 100);
        chk(rdata[SPCL_STAT_RX_FULL], 1'b1);
    endtask
    // Settings cross slowly; wait while idle
    task automatic setc(input logic [7:0] c);
        bus(1'b1, SPCL_ADDR_CONTROL, {24'h0, c});
        repeat (4) @(posedge clk_sys_in);
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev[i] = v[7 - i];
    endfunction
    // Verdict
    task automatic conclude;
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog far beyond the expected run
    initial
    begin
        #1000000;
        fail_count++;
        conclude;
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        @(posedge clk_sys_in);
        bus(1'b0, SPCL_ADDR_CONTROL, 32'h0);
        chk(rdata, SPCL_CONTROL_RESET);
        bus(1'b1, 8'h10, 32'hffff);
        bus(1'b0, 8'h10, 32'h0);
        chk(rdata, 32'h0);
        sel <= 4'h2;
        bus(1'b1, SPCL_ADDR_CONTROL, 32'h5aff);
        sel <= 4'hf;
        bus(1'b0, SPCL_ADDR_CONTROL, 32'h0);
        chk(rdata, 32'h5a00);
        // All polarity, phase and order pairs, write triggered
        for (int m = 0; m < 8; m++)
        begin
            mode <= m[0] ^ m[1] ^ m[2];
            reply <= 8'h3a + 8'(m);
            b = 8'hc4 + 8'(m);
            setc({2'b01, m[2], m[1], m[0], m[1] ^ m[2], 2'b11});
            bus(1'b1, SPCL_ADDR_TRANSMIT_DATA_REGISTER, {24'h0, b});
            wait_rx;
            bus(1'b0, SPCL_ADDR_RECEIVE_DATA, 32'h0);
            chk(rdata[7:0], m[2] ? rev(reply) : reply);
            chk(got, m[2] ? rev(b) : b);
            repeat (5) @(posedge clk_sys_in);
            bus(1'b0, SPCL_ADDR_STATUS, 32'h0);
            chk(rdata, 32'h8);
            chk(evt, 1'b1);
        end
        // Read triggered with nothing queued: last byte, then zeros
        mode <= 1'b0;
        for (int z = 0; z < 2; z++)
        begin
            setc({z[0], 7'h03});
            bus(1'b0, SPCL_ADDR_RECEIVE_DATA, 32'h0);
            wait_rx;
            chk(evt, 1'b1);
            chk(got, z ? 8'h00 : 8'hcb);
            bus(1'b0, SPCL_ADDR_RECEIVE_DATA, 32'h0);
            wait_rx;
        end
        chk(frames, 12);
        // Disabled master, unselected slave: no frames
        setc(8'h42);
        chk(evt, 1'b0);
        bus(1'b1, SPCL_ADDR_TRANSMIT_DATA_REGISTER, 32'h55);
        setc(8'h41);
        bus(1'b1, SPCL_ADDR_TRANSMIT_DATA_REGISTER, 32'h55);
        repeat (40) @(posedge clk_sys_in);
        chk(frames, 12);
        conclude;
    end
endmodule
